// >>> hw/see_pkg.sv
// shared constants for the serial eeprom two-wire link, both ends
// assumes a 250 MHz system clock on both ends
package see_pkg;
	localparam int CLK_KHZ            = 250000;
	// slave address layout
	localparam logic [3:0] DEV_TYPE   = 4'hA;
	localparam int ADDR_TYPE_MSB      = 7;
	localparam int ADDR_TYPE_LSB      = 4;
	localparam int ADDR_SEL_MSB       = 3;
	localparam int ADDR_SEL_LSB       = 1;
	localparam int ADDR_DIR_BIT       = 0;
	localparam logic DIR_READ         = 1'h1;
	// byte framing
	localparam logic [3:0] BIT_LAST   = 4'h7;
	localparam logic [3:0] BIT_ACK    = 4'h8;
	localparam int PAGE_BITS          = 5;
	localparam int MEM_WORDS_DEF      = 8192;
	localparam int PROT_DIV           = 4;
	// timing
	localparam int PROGRAM_CYCLE_TIME_MS  = 10;
	localparam int POWERUP_READ_DELAY_MS  = 1;
	localparam int POWERUP_WRITE_DELAY_MS = 1;
	localparam int PROG_CYCLES_DEF    = PROGRAM_CYCLE_TIME_MS * CLK_KHZ;
	localparam int PWRUP_CYCLES_DEF   =
		(POWERUP_READ_DELAY_MS > POWERUP_WRITE_DELAY_MS ?
		 POWERUP_READ_DELAY_MS : POWERUP_WRITE_DELAY_MS) * CLK_KHZ;
	localparam int SCL_KHZ            = 400;
	localparam int QTR_CYCLES_DEF     = CLK_KHZ / (SCL_KHZ * 4);
	localparam logic [1:0] QTR_LAST   = 2'h3;
	localparam logic [1:0] QTR_HIGH   = 2'h2;
	localparam logic [1:0] QTR_SET    = 2'h1;
	// device byte roles
	typedef enum logic [1:0] {
		K_SLAVE = 2'h0,
		K_HI    = 2'h1,
		K_LO    = 2'h2,
		K_DATA  = 2'h3
	} see_kind_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_RX   = 3'h1,
		S_RACK = 3'h2,
		S_TX   = 3'h3,
		S_TACK = 3'h4,
		S_WAIT = 3'h5
	} see_state_t;
	// host commands
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2,
		OP_STOP  = 2'h3
	} see_op_t;
endpackage

// >>> hw/see_if.sv
// two-wire link between the eeprom device end and the bus master end
// assumes pull-ups: a released line reads high
`timescale 1ns/1ns
interface see_if;
	logic m_scl_lvl;
	logic m_scl_oe_n;
	logic m_sda_lvl;
	logic m_sda_oe_n;
	logic d_sda_lvl;
	logic d_sda_oe_n;
	logic scl;
	logic sda;
	assign scl = m_scl_oe_n | m_scl_lvl;
	assign sda = (m_sda_oe_n | m_sda_lvl) & (d_sda_oe_n | d_sda_lvl);
	modport dev(input scl, input sda, output d_sda_lvl, output d_sda_oe_n);
	modport host(input sda, output m_scl_lvl, output m_scl_oe_n,
		output m_sda_lvl, output m_sda_oe_n);
endinterface

// >>> hw/see_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock; ce low freezes it
`timescale 1ns/1ns
module see_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// clock
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end
	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          push;
	logic          pop;
	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + CW'(1);
		else if (pop && !push)
			cnt_d = cnt_q - CW'(1);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q     <= '0;
			rd_q     <= '0;
			cnt_q    <= '0;
			in_ready <= 1'h0;
		end else if (ce) begin
			cnt_q    <= cnt_d;
			in_ready <= cnt_d != CW'(DEPTH);
			if (push)
				wr_q <= wr_q + PW'(1);
			if (pop)
				rd_q <= rd_q + PW'(1);
		end
	end
	// storage needs no reset; only counted words are ever read
	always_ff @(posedge clk) begin
		if (ce && push)
			mem_q[wr_q] <= in_data;
	end
endmodule // see_fifo

// >>> hw/see_host.sv
// bus master end: runs queued start/write/read/stop commands on the link
// assumes the user follows the documented command order for each transfer
`timescale 1ns/1ns
module see_host #(
	parameter int QTR_CYCLES   = see_pkg::QTR_CYCLES_DEF,
	parameter int PWRUP_CYCLES = see_pkg::PWRUP_CYCLES_DEF,
	parameter int FIFO_DEPTH   = 16
) (
	// clock
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// link
	see_if.host             bus,
	// command queue
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [1:0] cmd_op,
	input  wire logic       cmd_nack,
	input  wire logic [7:0] cmd_data,
	// answers
	output logic            rsp_valid,
	output logic            rsp_ack,
	output logic [7:0]      rsp_data,
	output logic            ready_q
);
	localparam int QW = $clog2(QTR_CYCLES + 1);
	localparam int PU = $clog2(PWRUP_CYCLES + 1);
	if (QTR_CYCLES < 4) begin : g_chk
		$error("quarter period too short for the device synchroniser");
	end
	logic [10:0]   f_data;
	logic          f_valid;
	logic          take;
	logic          tick;
	logic [1:0]    sda_s;
	logic          act_q;
	see_pkg::see_op_t op_q;
	logic          nack_q;
	logic [7:0]    sh_q;
	logic [1:0]    qtr_q;
	logic [3:0]    bit_q;
	logic [QW-1:0] div_q;
	logic [PU-1:0] pu_q;
	logic          last;

	see_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk), .rst(rst), .ce(ce),
		.in_valid(cmd_valid), .in_ready(cmd_ready),
		.in_data({cmd_op, cmd_nack, cmd_data}),
		.out_valid(f_valid), .out_ready(take), .out_data(f_data));

	assign take = f_valid & ready_q;
	assign tick = act_q & (div_q == QW'(QTR_CYCLES - 1));
	assign last = (op_q == see_pkg::OP_START || op_q == see_pkg::OP_STOP)
		|| bit_q == see_pkg::BIT_ACK;

	// level of sda set in quarter 1 (scl low); 1 = release
	function automatic logic sda_set(see_pkg::see_op_t op, logic [3:0] b,
		logic [7:0] d, logic nk);
		unique case (op)
			see_pkg::OP_START: sda_set = 1'h1;
			see_pkg::OP_STOP:  sda_set = 1'h0;
			see_pkg::OP_WRITE: sda_set = b == see_pkg::BIT_ACK ? 1'h1 : d[7];
			see_pkg::OP_READ:  sda_set = b == see_pkg::BIT_ACK ? nk : 1'h1;
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sda_s <= 2'h3;
		else if (ce)
			sda_s <= {sda_s[0], bus.sda};
	end

	// no command before the supply settle time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pu_q    <= PU'(PWRUP_CYCLES);
			ready_q <= 1'h0;
		end else if (ce) begin
			if (pu_q != '0)
				pu_q <= pu_q - PU'(1);
			ready_q <= pu_q == '0 && !act_q && !take;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_q  <= 1'h0;
			op_q   <= see_pkg::OP_STOP;
			nack_q <= 1'h0;
			sh_q   <= '0;
			qtr_q  <= '0;
			bit_q  <= '0;
			div_q  <= '0;
		end else if (ce) begin
			if (take) begin
				act_q  <= 1'h1;
				op_q   <= see_pkg::see_op_t'(f_data[10:9]);
				nack_q <= f_data[8];
				sh_q   <= f_data[7:0];
				qtr_q  <= '0;
				bit_q  <= '0;
				div_q  <= '0;
			end else if (act_q) begin
				div_q <= tick ? '0 : div_q + QW'(1);
				if (tick) begin
					qtr_q <= qtr_q + 2'h1;
					// the ack slot is ours, not data: keep it out of the byte
					if (qtr_q == see_pkg::QTR_HIGH && op_q == see_pkg::OP_READ
						&& bit_q != see_pkg::BIT_ACK)
						sh_q <= {sh_q[6:0], sda_s[1]};
					else if (qtr_q == see_pkg::QTR_LAST)
						sh_q <= op_q == see_pkg::OP_WRITE ?
							{sh_q[6:0], 1'h0} : sh_q;
					if (qtr_q == see_pkg::QTR_LAST) begin
						bit_q <= bit_q + 4'h1;
						if (last)
							act_q <= 1'h0;
					end
				end
			end
		end
	end

	// scl low in quarters 0-1, high in 2-3; sda moves only while scl low,
	// except the start/stop edge in quarter 3
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.m_scl_lvl  <= 1'h0;
			bus.m_sda_lvl  <= 1'h0;
			bus.m_scl_oe_n <= 1'h1;
			bus.m_sda_oe_n <= 1'h1;
		end else if (ce && act_q) begin
			bus.m_scl_oe_n <= qtr_q[1];
			if (qtr_q == see_pkg::QTR_SET)
				bus.m_sda_oe_n <= sda_set(op_q, bit_q, sh_q, nack_q);
			else if (qtr_q == see_pkg::QTR_LAST && op_q == see_pkg::OP_START)
				bus.m_sda_oe_n <= 1'h0;
			else if (qtr_q == see_pkg::QTR_LAST && op_q == see_pkg::OP_STOP)
				bus.m_sda_oe_n <= 1'h1;
		end
	end

	// answers for byte commands; the user sequences them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'h0;
			rsp_ack   <= 1'h0;
			rsp_data  <= '0;
		end else if (ce) begin
			rsp_valid <= 1'h0;
			if (tick && qtr_q == see_pkg::QTR_HIGH && bit_q == see_pkg::BIT_ACK
				&& op_q == see_pkg::OP_WRITE) begin
				rsp_ack   <= !sda_s[1];
				rsp_valid <= 1'h1;
			end
			if (tick && qtr_q == see_pkg::QTR_LAST && bit_q == see_pkg::BIT_ACK
				&& op_q == see_pkg::OP_READ) begin
				rsp_data  <= sh_q;
				rsp_ack   <= !nack_q;
				rsp_valid <= 1'h1;
			end
		end
	end
endmodule // see_host

// >>> hw/see_dev.sv
// device end: two-wire slave of a serial eeprom with page buffer
// assumes the master makes scl; scl and sda are asynchronous to clk
`timescale 1ns/1ns
// Functional notes
// - after write stop, busy, ignore everything
// - master waits power-up delay before access
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - sda moves only while scl low
// - respond only to 1010 plus straps
// - address lsb selects read or write
// - receiver pulls sda low on ninth pulse
// - ack own address and written bytes
// - read: master ack continues, nack stops
// - byte write: address, two offsets, data
// - page write up to 32, low bits count
// - page overflow wraps within page
// - busy: withhold ack for write address
// - write protect locks lowest quarter
// - protected: ack addresses, nack first data
// - protect low: whole array writable
// - counter holds last address plus one
// - random read: dummy write then restart
// - sequential read increments whole counter, wraps
module see_dev #(
	parameter int MEM_WORDS   = see_pkg::MEM_WORDS_DEF,
	parameter int PROG_CYCLES = see_pkg::PROG_CYCLES_DEF
) (
	// clock
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// link
	see_if.dev        bus,
	// straps
	input  wire logic chip_select_strap_0,
	input  wire logic chip_select_strap_1,
	input  wire logic chip_select_strap_2,
	input  wire logic write_protect,
	// status
	output logic      prog_busy
);
	localparam int AW = $clog2(MEM_WORDS);
	localparam int PB = see_pkg::PAGE_BITS;
	localparam int PN = 1 << PB;
	localparam int BW = $clog2(PROG_CYCLES + 1);
	if (MEM_WORDS != 4096 && MEM_WORDS != 8192) begin : g_chk
		$error("array must hold 4096 or 8192 bytes");
	end

	logic [7:0]    mem_q [MEM_WORDS];
	logic [7:0]    pbuf_q [PN];
	logic [PN-1:0] pmask_q;
	logic [AW-1:PB] page_q;
	logic          commit_q;
	logic [BW-1:0] bcnt_q;
	logic [1:0]    scl_s;
	logic [1:0]    sda_s;
	logic [3:0]    pin_m_q;
	logic [3:0]    pin_q;
	logic          scl_p;
	logic          sda_p;
	see_pkg::see_state_t st_q;
	see_pkg::see_kind_t  kind_q;
	logic [3:0]    cnt_q;
	logic [7:0]    sh_q;
	logic          ack_q;
	logic          rd_q;
	logic [AW-1:0] addr_q;
	logic          rise;
	logic          fall;
	logic          start;
	logic          stop;
	logic [7:0]    rxb;
	logic          sel;
	logic          tx_go;

	function automatic logic prot(logic [AW-1:0] a);
		prot = a < AW'(MEM_WORDS / see_pkg::PROT_DIV);
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_p <= 1'h1;
			sda_p <= 1'h1;
			// open straps and protect pin read as zero
			pin_m_q <= '0;
			pin_q   <= '0;
		end else if (ce) begin
			scl_s <= {scl_s[0], bus.scl};
			sda_s <= {sda_s[0], bus.sda};
			pin_m_q <= {write_protect, chip_select_strap_2,
				chip_select_strap_1, chip_select_strap_0};
			pin_q   <= pin_m_q;
			scl_p <= scl_s[1];
			sda_p <= sda_s[1];
		end
	end

	assign rise  = scl_s[1] & !scl_p;
	assign fall  = !scl_s[1] & scl_p;
	// any sda change with scl high is a condition
	assign start = scl_s[1] & scl_p & sda_p & !sda_s[1];
	assign stop  = scl_s[1] & scl_p & !sda_p & sda_s[1];
	assign rxb   = {sh_q[6:0], sda_s[1]};
	assign sel   = rxb[see_pkg::ADDR_TYPE_MSB:see_pkg::ADDR_TYPE_LSB]
			== see_pkg::DEV_TYPE
		&& rxb[see_pkg::ADDR_SEL_MSB:see_pkg::ADDR_SEL_LSB]
			== pin_q[2:0];
	assign tx_go = fall && ((st_q == see_pkg::S_RACK && rd_q)
		|| (st_q == see_pkg::S_TACK && ack_q));

	// protocol engine; held idle through a program cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q           <= see_pkg::S_IDLE;
			kind_q         <= see_pkg::K_SLAVE;
			cnt_q          <= '0;
			sh_q           <= '0;
			ack_q          <= 1'h0;
			rd_q           <= 1'h0;
			addr_q         <= '0;
			pmask_q        <= '0;
			page_q         <= '0;
			commit_q       <= 1'h0;
			bus.d_sda_oe_n <= 1'h1;
		end else if (ce) begin
			commit_q <= 1'h0;
			if (commit_q)
				pmask_q <= '0;
			if (prog_busy || commit_q) begin
				st_q           <= see_pkg::S_IDLE;
				bus.d_sda_oe_n <= 1'h1;
			end else if (start) begin
				st_q           <= see_pkg::S_RX;
				kind_q         <= see_pkg::K_SLAVE;
				cnt_q          <= '0;
				bus.d_sda_oe_n <= 1'h1;
			end else if (stop) begin
				st_q           <= see_pkg::S_IDLE;
				bus.d_sda_oe_n <= 1'h1;
				commit_q       <= |pmask_q;
			end else if (tx_go) begin
				st_q           <= see_pkg::S_TX;
				cnt_q          <= '0;
				sh_q           <= mem_q[addr_q];
				bus.d_sda_oe_n <= mem_q[addr_q][7];
				addr_q         <= addr_q + AW'(1);
			end else begin
				unique case (st_q)
					see_pkg::S_IDLE, see_pkg::S_WAIT: begin
					end
					see_pkg::S_RX: begin
						if (rise) begin
							sh_q  <= rxb;
							cnt_q <= cnt_q + 4'h1;
						end
						if (rise && cnt_q == see_pkg::BIT_LAST) begin
							ack_q <= 1'h1;
							unique case (kind_q)
								see_pkg::K_SLAVE: begin
									ack_q  <= sel;
									rd_q   <= rxb[see_pkg::ADDR_DIR_BIT]
										== see_pkg::DIR_READ;
									kind_q <= see_pkg::K_HI;
								end
								see_pkg::K_HI: begin
									addr_q[AW-1:8] <= rxb[AW-9:0];
									kind_q         <= see_pkg::K_LO;
								end
								see_pkg::K_LO: begin
									addr_q[7:0] <= rxb;
									kind_q      <= see_pkg::K_DATA;
								end
								see_pkg::K_DATA: begin
									if (pin_q[3] && prot(addr_q))
										ack_q <= 1'h0;
									else begin
										pbuf_q[addr_q[PB-1:0]]  <= rxb;
										pmask_q[addr_q[PB-1:0]] <= 1'h1;
										page_q <= addr_q[AW-1:PB];
										// only the page bits count
										addr_q[PB-1:0] <= addr_q[PB-1:0] + PB'(1);
									end
								end
							endcase
						end
						if (fall && cnt_q == see_pkg::BIT_ACK) begin
							st_q <= ack_q ? see_pkg::S_RACK : see_pkg::S_WAIT;
							bus.d_sda_oe_n <= !ack_q;
						end
					end
					see_pkg::S_RACK: begin
						if (fall) begin
							st_q           <= see_pkg::S_RX;
							cnt_q          <= '0;
							bus.d_sda_oe_n <= 1'h1;
						end
					end
					see_pkg::S_TX: begin
						if (rise)
							cnt_q <= cnt_q + 4'h1;
						if (fall && cnt_q == see_pkg::BIT_ACK) begin
							st_q           <= see_pkg::S_TACK;
							bus.d_sda_oe_n <= 1'h1;
						end else if (fall) begin
							sh_q           <= {sh_q[6:0], 1'h0};
							bus.d_sda_oe_n <= sh_q[6];
						end
					end
					see_pkg::S_TACK: begin
						if (rise)
							ack_q <= !sda_s[1];
						if (fall)
							st_q <= see_pkg::S_WAIT;
					end
					default: begin
						st_q <= see_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: the level is always low, the enable does the work
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bus.d_sda_lvl <= 1'h0;
		else if (ce)
			bus.d_sda_lvl <= 1'h0;
	end

	// program cycle timer; counts the full worst case, no early finish
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bcnt_q    <= '0;
			prog_busy <= 1'h0;
		end else if (ce) begin
			if (commit_q) begin
				bcnt_q    <= BW'(PROG_CYCLES - 1);
				prog_busy <= 1'h1;
			end else if (bcnt_q != '0)
				bcnt_q <= bcnt_q - BW'(1);
			else
				prog_busy <= 1'h0;
		end
	end

	// loaded page bytes written at once at the start of the program cycle
	always_ff @(posedge clk) begin
		if (ce && commit_q) begin
			for (int i = 0; i < PN; i++) begin
				if (pmask_q[i])
					mem_q[{page_q, PB'(i)}] <= pbuf_q[i];
			end
		end
	end
endmodule // see_dev

// >>> sim/see_link_properties.sv
// wire-level checks on the link between host end and device end
// assumes scl and sda come from registers clocked by clk
`timescale 1ns/1ns
module see_link_properties #(
	parameter int PROG_CYCLES = 2000
) (
	// clock
	input wire logic clk,
	input wire logic rst,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_lvl,
	input wire logic d_sda_oe_n,
	// device straps and status
	input wire logic chip_select_strap_0,
	input wire logic chip_select_strap_1,
	input wire logic chip_select_strap_2,
	input wire logic prog_busy
);
	logic       scl_q, sda_q, seen_q, first_q, mute_q, bsy_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	int         cnt_q, age_q;
	logic       start, stop, rise, match;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;
	assign rise  = scl & ~scl_q;
	assign match = shift_q[7:1] == {see_pkg::DEV_TYPE, chip_select_strap_2,
		chip_select_strap_1, chip_select_strap_0};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// byte framing as seen on the wire
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_q <= 4'h0;
			first_q <= 1'h0;
			shift_q <= 8'h00;
		end else if (start) begin
			bit_q <= 4'h0;
			first_q <= 1'h1;
		end else if (rise && bit_q == 4'h8) begin
			bit_q <= 4'h0;
			first_q <= 1'h0;
		end else if (rise) begin
			bit_q <= bit_q + 4'h1;
			shift_q <= {shift_q[6:0], sda};
		end
	end
	// a missed address mutes the device until the next start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_q <= 1'h0;
			mute_q <= 1'h0;
			bsy_q <= 1'h0;
		end else if (start) begin
			seen_q <= 1'h1;
			mute_q <= 1'h0;
			bsy_q <= prog_busy;
		end else begin
			if (rise && first_q && bit_q == 4'h8 && !match)
				mute_q <= 1'h1;
			if (prog_busy)
				bsy_q <= 1'h1;
		end
	end
	// program cycle length and distance from the last stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 0;
			age_q <= 1000;
		end else begin
			cnt_q <= prog_busy ? cnt_q + 1 : 0;
			if (stop)
				age_q <= 0;
			else if (age_q < 1000)
				age_q <= age_q + 1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence ninth_addr;
		rise && first_q && bit_q == 4'h8;
	endsequence
	sequence dev_acks;
		!d_sda_oe_n;
	endsequence
	a_busy_silent: assert property (prog_busy |-> d_sda_oe_n)
		else $error("device drives sda in program cycle");
	a_busy_length: assert property ($fell(prog_busy) |->
		cnt_q >= PROG_CYCLES - 1 && cnt_q <= PROG_CYCLES + 1)
		else $error("program cycle length wrong");
	a_busy_after_stop: assert property ($rose(prog_busy) |-> age_q <= 12)
		else $error("program cycle not started by a stop");
	a_quiet_before_start: assert property (!seen_q |-> d_sda_oe_n)
		else $error("device drives sda before any start");
	a_mute_after_miss: assert property (mute_q |-> d_sda_oe_n)
		else $error("device drives sda after address miss");
	a_addr_answer: assert property (ninth_addr |->
		((match && !bsy_q) == !d_sda_oe_n))
		else $error("address acknowledge wrong");
	a_ack_stands: assert property (ninth_addr ##0 dev_acks |=> dev_acks[*4])
		else $error("acknowledge released early");
	a_sda_scl_low: assert property ($changed(d_sda_oe_n) |-> !scl)
		else $error("device moves sda while scl high");
	a_drive_low: assert property (!d_sda_oe_n |-> !d_sda_lvl)
		else $error("device drives sda high");
endmodule // see_link_properties

// >>> sim/tb_serial_eeprom_bus_slave.sv
// bench: host end drives the device end over one link
// assumes host commands are taken in queue order
`timescale 1ns/1ns
module tb_serial_eeprom_bus_slave;
	localparam int PROG = 2000;
	localparam int PWRUP = 50;
	logic       clk, rst, cmd_valid, cmd_ready, cmd_nack, wp, ce;
	logic       rsp_valid, rsp_ack, ready_q, busy;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data;
	logic [2:0] strap;
	logic [7:0] mem [int];
	int         seed = 32'h68fe;
	int         n_errors = 0;
	int         n_compared = 0;
	int         a;
	see_if bus();
	see_host #(.QTR_CYCLES(10), .PWRUP_CYCLES(PWRUP), .FIFO_DEPTH(16)) u_see_host (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_nack(cmd_nack),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
		.rsp_data(rsp_data), .ready_q(ready_q));
	see_dev #(.MEM_WORDS(8192), .PROG_CYCLES(PROG)) u_see_dev (
		.clk(clk), .rst(rst), .ce(ce), .bus(bus),
		.chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_2(strap[2]), .write_protect(wp), .prog_busy(busy));
	see_link_properties #(.PROG_CYCLES(PROG)) u_see_link_properties (
		.clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
		.d_sda_lvl(bus.d_sda_lvl), .d_sda_oe_n(bus.d_sda_oe_n),
		.chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_2(strap[2]), .prog_busy(busy));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	function automatic logic [7:0] dev(input logic rd);
		return {see_pkg::DEV_TYPE, strap, rd};
	endfunction
	task automatic chk(input string what, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic push(input logic [1:0] op, input logic nk, input logic [7:0] d);
		@(posedge clk);
		#1;
		cmd_valid = 1'h1;
		cmd_op = op;
		cmd_nack = nk;
		cmd_data = d;
		do @(posedge clk); while (cmd_ready !== 1'h1);
		#1;
		cmd_valid = 1'h0;
	endtask
	task automatic xfer(input logic [1:0] op, input logic nk, input logic [7:0] d);
		int k;
		push(op, nk, d);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rsp_valid !== 1'h1 && k < 2000);
		if (rsp_valid !== 1'h1) begin
			n_errors++;
			$display("unexpected rsp_valid: expected 1 seen 0");
		end
	endtask
	task automatic wr(input logic [7:0] d, input logic e);
		xfer(see_pkg::OP_WRITE, 1'h0, d);
		chk("ack", {7'h0, e}, {7'h0, rsp_ack});
	endtask
	// upper bits of the high byte are random: the device must drop them
	task automatic addr(input int x);
		int r;
		r = $random(seed);
		push(see_pkg::OP_START, 1'h0, 8'h00);
		wr(dev(1'h0), 1'h1);
		wr({r[2:0], x[12:8]}, 1'h1);
		wr(x[7:0], 1'h1);
	endtask
	task automatic poll(input logic first);
		int k;
		for (k = 0; k < 8; k++) begin
			push(see_pkg::OP_START, 1'h0, 8'h00);
			xfer(see_pkg::OP_WRITE, 1'h0, dev(1'h0));
			push(see_pkg::OP_STOP, 1'h0, 8'h00);
			if (k == 0) chk("poll first", {7'h0, first}, {7'h0, rsp_ack});
			if (rsp_ack === 1'h1) break;
		end
		chk("poll end", 8'h01, {7'h0, rsp_ack});
	endtask
	task automatic wseq(input int x, input int n, input logic prot);
		int i;
		logic [7:0] d;
		addr(x);
		for (i = 0; i < n; i++) begin
			d = $random(seed);
			wr(d, !prot);
			if (prot) break;
			mem[{x[12:5], x[4:0] + i[4:0]}] = d;
		end
		push(see_pkg::OP_STOP, 1'h0, 8'h00);
		poll(prot);
	endtask
	task automatic rseq(input int x, input int n);
		int i;
		addr(x);
		push(see_pkg::OP_START, 1'h0, 8'h00);
		wr(dev(1'h1), 1'h1);
		for (i = 0; i < n; i++) begin
			xfer(see_pkg::OP_READ, i == n - 1, 8'h00);
			chk("data", mem[(x + i) % 8192], rsp_data);
		end
		push(see_pkg::OP_STOP, 1'h0, 8'h00);
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#(95000 * 4);
		n_errors++;
		final_report();
	end
	initial begin
		rst = 1'h1;
		cmd_valid = 1'h0;
		cmd_op = 2'h0;
		cmd_nack = 1'h0;
		cmd_data = 8'h00;
		wp = 1'h0;
		ce = 1'h1;
		strap = $random(seed);
		repeat (5) @(posedge clk);
		#1;
		rst = 1'h0;
		for (a = 0; a < 500 && ready_q !== 1'h1; a++) @(posedge clk);
		chk("powerup wait", 8'h01, {7'h0, a >= PWRUP});
		push(see_pkg::OP_START, 1'h0, 8'h00);
		wr({4'h5, strap, 1'h0}, 1'h0);
		push(see_pkg::OP_START, 1'h0, 8'h00);
		wr({see_pkg::DEV_TYPE, strap ^ 3'h4, 1'h0}, 1'h0);
		push(see_pkg::OP_STOP, 1'h0, 8'h00);
		$display("test address miss done");
		// freeze both ends in the ack bit of the missed address, stop still queued; the next tests must still pass
		@(posedge clk);
		#1;
		ce = 1'h0;
		repeat (20) @(posedge clk);
		#1;
		ce = 1'h1;
		a = ($random(seed) & 32'h17E0) | 32'h0805;
		wseq(a, 2, 1'h0);
		rseq(a, 1);
		push(see_pkg::OP_START, 1'h0, 8'h00);
		wr(dev(1'h1), 1'h1);
		xfer(see_pkg::OP_READ, 1'h1, 8'h00);
		chk("current", mem[a + 1], rsp_data);
		push(see_pkg::OP_STOP, 1'h0, 8'h00);
		$display("test byte write and reads done");
		a = ($random(seed) & 32'h17E0) | 32'h081E;
		wseq(a, 34, 1'h0);
		rseq(a - 2, 4);
		$display("test page wrap done");
		wseq(32'h07FF, 1, 1'h0);
		wp = 1'h1;
		wseq(32'h07FF, 1, 1'h1);
		a = $random(seed) & 32'h07FF;
		wseq(a, 1, 1'h1);
		wp = 1'h0;
		rseq(32'h07FF, 1);
		$display("test write protect done");
		wseq(8191, 1, 1'h0);
		wseq(0, 1, 1'h0);
		rseq(8191, 2);
		$display("test counter wrap done");
		final_report();
	end
endmodule // tb_serial_eeprom_bus_slave
